// ===== src/lcr_top.sv
/*
 * lcr_top: read-only laser capability registers behind an APB slave,
 * with a response register holding status and error condition of the
 * last capability read, an error-forcing control, and interrupts.
 * Assumes an APB master on sys_clk; cap_ready_pin is asynchronous.
 */
module lcr_top
	import lcr_pkg::*;
#(
	parameter logic [15:0] MIN_POWER = 16'h0064,
	parameter logic [15:0] MAX_POWER = 16'h0578,
	parameter logic [15:0] LOW_THZ   = 16'h00bf,
	parameter logic [15:0] LOW_FRAC  = 16'h0000,
	parameter logic [15:0] HIGH_THZ  = 16'h00c4,
	parameter logic [15:0] HIGH_FRAC = 16'h0000,
	parameter logic [15:0] MIN_GRID  = 16'h0007
)
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cap_ready_pin,
	output logic             irq
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (MIN_GRID == 16'h0000) begin : g_bad_grid
		$error("grid spacing must be positive");
	end
	if ($signed(MIN_POWER) > $signed(MAX_POWER)) begin : g_bad_power
		$error("minimum power above maximum power");
	end
	if (LOW_FRAC > 16'h270f || HIGH_FRAC > 16'h270f) begin : g_bad_frac
		$error("frequency remainder must stay below one terahertz");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		lcr_phase_type phase;
		logic [31:0]   prdata;
		logic          pslverr;
		logic          rd_fail;
		logic [2:0]    pend_code;
		logic [1:0]    status;
		logic [2:0]    code;
		logic [2:0]    force_code;
	} lcr_state_type;

	lcr_state_type st_r;
	lcr_state_type st_nxt;

	logic                ready_s;
	logic [LCR_EV_N-1:0] ev_set;
	logic [LCR_EV_N-1:0] ev_clr;
	logic                mask_we;
	logic [LCR_EV_N-1:0] irq_status;
	logic [LCR_EV_N-1:0] irq_mask;

	lcr_sync2 u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.d_async (cap_ready_pin),
		.q       (ready_s)
	);

	// ****************************************************************
	// address decode
	// ****************************************************************
	logic [7:0]  idx;
	logic        in_map;
	logic        cap_sel;
	logic        ctrl_sel;
	logic        resp_sel;
	logic        istat_sel;
	logic        imask_sel;
	logic [15:0] cap_val;
	logic        force_ok;
	logic        fail;
	logic [2:0]  fail_code;
	logic        setup;
	logic        done;

	assign idx      = paddr[9:2];
	assign in_map   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
	assign cap_sel  = in_map && (idx >= LCR_IDX_MIN_POWER) && (idx <= LCR_IDX_MIN_GRID);
	assign ctrl_sel  = in_map && (idx == LCR_IDX_CTRL);
	assign resp_sel  = in_map && (idx == LCR_IDX_RESP);
	assign istat_sel = in_map && (idx == LCR_IDX_IRQ_STATUS);
	assign imask_sel = in_map && (idx == LCR_IDX_IRQ_MASK);

	always_comb begin
		case (idx)
			LCR_IDX_MIN_POWER: cap_val = MIN_POWER;
			LCR_IDX_MAX_POWER: cap_val = MAX_POWER;
			LCR_IDX_LOW_THZ:   cap_val = LOW_THZ;
			LCR_IDX_LOW_FRAC:  cap_val = LOW_FRAC;
			LCR_IDX_HIGH_THZ:  cap_val = HIGH_THZ;
			LCR_IDX_HIGH_FRAC: cap_val = HIGH_FRAC;
			LCR_IDX_MIN_GRID:  cap_val = MIN_GRID;
			default:           cap_val = 16'h0000;
		endcase
	end

	// a forced code outside the four defined error codes is ignored
	assign force_ok  = (st_r.force_code >= LCR_CODE_COMMAND_IN_PROGRESS) &&
	                   (st_r.force_code <= LCR_CODE_VENDOR_SPECIFIC_ERROR);
	assign fail      = force_ok || !ready_s;
	assign fail_code = force_ok ? st_r.force_code :
	                   (!ready_s ? LCR_CODE_COMMAND_IN_PROGRESS : LCR_CODE_OK);

	assign setup = psel && !penable;
	assign done  = psel && penable && (st_r.phase == LCR_PH_ACCESS);

	// response word, status and error-condition fields at their package positions
	logic [31:0] resp_word;

	always_comb begin
		resp_word                         = 32'h0000_0000;
		resp_word[LCR_RESP_STAT_LSB +: 2] = st_r.status;
		resp_word[LCR_RESP_CODE_LSB +: 3] = st_r.code;
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	always_comb begin
		st_nxt  = st_r;
		ev_set  = '0;
		ev_clr  = '0;
		mask_we = 1'b0;
		if (setup) begin
			st_nxt.phase   = LCR_PH_ACCESS;
			st_nxt.prdata  = 32'h0000_0000;
			st_nxt.pslverr = 1'b0;
			st_nxt.rd_fail = 1'b0;
			if (!in_map || !(cap_sel || ctrl_sel || resp_sel || istat_sel || imask_sel)) begin
				st_nxt.pslverr = 1'b1;
			end else if (pwrite) begin
				st_nxt.pslverr = cap_sel || resp_sel;
			end else if (cap_sel) begin
				st_nxt.rd_fail   = fail;
				st_nxt.pend_code = fail_code;
				st_nxt.prdata    = fail ? 32'h0000_0000 : {16'h0000, cap_val};
			end else if (ctrl_sel) begin
				st_nxt.prdata = {29'h0, st_r.force_code};
			end else if (resp_sel) begin
				st_nxt.prdata = resp_word;
			end else if (istat_sel) begin
				st_nxt.prdata = {30'h0, irq_status};
			end else begin
				st_nxt.prdata = {30'h0, irq_mask};
			end
		end
		if (done) begin
			st_nxt.phase = LCR_PH_IDLE;
			if (!pwrite && cap_sel) begin
				if (st_r.rd_fail) begin
					st_nxt.status = LCR_STAT_EXECUTION_ERROR_STATUS;
					st_nxt.code   = st_r.pend_code;
					ev_set[LCR_EV_READ_ERR] = 1'b1;
				end else begin
					st_nxt.status = LCR_STAT_OK;
					st_nxt.code   = LCR_CODE_OK;
					ev_set[LCR_EV_READ_OK] = 1'b1;
				end
			end else if (pwrite && pstrb[0]) begin
				if (ctrl_sel) begin
					st_nxt.force_code = pwdata[2:0];
				end
				if (istat_sel) begin
					ev_clr = pwdata[LCR_EV_N-1:0];
				end
				mask_we = imask_sel;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r            <= '0;
			st_r.phase      <= LCR_PH_IDLE;
			st_r.status     <= LCR_STAT_OK;
			st_r.code       <= LCR_CODE_OK;
			st_r.force_code <= LCR_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// a capability read answers in its first access cycle, never pends
	assign pready  = (st_r.phase == LCR_PH_ACCESS);
	assign prdata  = st_r.prdata;
	assign pslverr = st_r.pslverr & pready;

	// ****************************************************************
	// interrupts
	// ****************************************************************
	lcr_irq #(
		.N (LCR_EV_N)
	) u_irq (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.ev_set     (ev_set),
		.ev_clr     (ev_clr),
		.mask_we    (mask_we),
		.mask_wdata (pwdata[LCR_EV_N-1:0]),
		.status     (irq_status),
		.mask       (irq_mask),
		.irq        (irq)
	);

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	logic cap_rd_done;
	logic cap_rd_ok;
	logic cap_rd_setup;
	assign cap_rd_done  = done && !pwrite && cap_sel;
	assign cap_rd_ok    = cap_rd_done && !st_r.rd_fail;
	assign cap_rd_setup = setup && !pwrite && cap_sel;

	min_power_read_a: assert property (
		cap_rd_ok && paddr == LCR_ADDR_MIN_POWER |-> prdata == {16'h0000, MIN_POWER})
		else $error("minimum power read wrong");

	max_power_read_a: assert property (
		cap_rd_ok && paddr == LCR_ADDR_MAX_POWER |-> prdata == {16'h0000, MAX_POWER})
		else $error("maximum power read wrong");

	low_freq_pair_a: assert property (
		cap_rd_ok && (paddr == LCR_ADDR_LOW_THZ || paddr == LCR_ADDR_LOW_FRAC) |->
		prdata[15:0] == ((paddr == LCR_ADDR_LOW_THZ) ? LOW_THZ : LOW_FRAC))
		else $error("lowest frequency word wrong");

	high_freq_pair_a: assert property (
		cap_rd_ok && (paddr == LCR_ADDR_HIGH_THZ || paddr == LCR_ADDR_HIGH_FRAC) |->
		prdata == {16'h0000, (paddr == LCR_ADDR_HIGH_THZ) ? HIGH_THZ : HIGH_FRAC})
		else $error("highest frequency word wrong");

	grid_value_a: assert property (
		cap_rd_ok && paddr == LCR_ADDR_MIN_GRID |-> prdata[15:0] == MIN_GRID)
		else $error("grid spacing read wrong");

	grid_positive_a: assert property (
		cap_rd_ok && paddr == LCR_ADDR_MIN_GRID |-> prdata[15:0] != 16'h0000)
		else $error("grid spacing not positive");

	fail_read_zero_a: assert property (
		cap_rd_done && st_r.rd_fail |-> prdata == 32'h0000_0000 ##1
		(st_r.status == LCR_STAT_EXECUTION_ERROR_STATUS &&
		 st_r.code >= LCR_CODE_COMMAND_IN_PROGRESS &&
		 st_r.code <= LCR_CODE_VENDOR_SPECIFIC_ERROR && irq_status[LCR_EV_READ_ERR]))
		else $error("failed read not reported as execution error");

	ok_read_clean_a: assert property (
		cap_rd_ok |-> pready && !pslverr ##1
		(st_r.status == LCR_STAT_OK && st_r.code == LCR_CODE_OK &&
		 $stable(st_r.force_code) && st_r.phase == LCR_PH_IDLE))
		else $error("good read not clean");

	setup_answer_a: assert property (
		setup |=> pready)
		else $error("access phase not answered at once");

	// ****************************************************************
	// assertions: responses, events and refused accesses
	// ****************************************************************
	no_pending_a: assert property (
		cap_rd_setup |=> pready && !pslverr)
		else $error("capability read not answered at once");

	upper_half_zero_a: assert property (
		cap_rd_done |-> prdata[31:16] == 16'h0000)
		else $error("capability read upper half not zero");

	forced_code_a: assert property (
		cap_rd_setup && force_ok |=>
		st_r.rd_fail && st_r.pend_code == $past(st_r.force_code))
		else $error("forced error code not taken");

	in_progress_code_a: assert property (
		cap_rd_setup && !force_ok && !ready_s |=>
		st_r.rd_fail && st_r.pend_code == LCR_CODE_COMMAND_IN_PROGRESS)
		else $error("unready read not reported in progress");

	ready_read_ok_a: assert property (
		cap_rd_setup && !force_ok && ready_s |=> !st_r.rd_fail)
		else $error("ready read reported as failed");

	fail_no_slverr_a: assert property (
		cap_rd_done && st_r.rd_fail |-> !pslverr)
		else $error("failed read answered with bus error");

	ok_read_event_a: assert property (
		cap_rd_ok |=> irq_status[LCR_EV_READ_OK])
		else $error("good read event not raised");

	resp_hold_a: assert property (
		!cap_rd_done |=> $stable(st_r.status) && $stable(st_r.code))
		else $error("response changed without a capability read");

	force_hold_a: assert property (
		!(done && pwrite && ctrl_sel && pstrb[0]) |=> $stable(st_r.force_code))
		else $error("control changed without a control write");

	write_refused_a: assert property (
		done && pwrite && (cap_sel || resp_sel) |-> pslverr)
		else $error("write to read-only register not refused");

	bad_addr_refused_a: assert property (
		done && !in_map |-> pslverr && prdata == 32'h0000_0000)
		else $error("misaligned or outside access not refused");

	event_clear_a: assert property (
		done && pwrite && istat_sel && pstrb[0] && pwdata[LCR_EV_READ_ERR] |=>
		!irq_status[LCR_EV_READ_ERR])
		else $error("read error event not cleared");

	prdata_hold_a: assert property (
		!setup |=> $stable(prdata))
		else $error("read data changed outside a setup cycle");

	cov_ok_read_c:   cover property (cap_rd_ok ##1 irq_status[LCR_EV_READ_OK]);
	cov_fail_read_c: cover property (cap_rd_done && st_r.rd_fail);
	cov_irq_rise_c:  cover property (!irq ##1 irq);
	cov_forced_c:    cover property (cap_rd_done && force_ok);
	cov_ro_write_c:  cover property (done && pwrite && cap_sel);

endmodule : lcr_top

// ===== src/lcr_pkg.sv
/*
 * lcr_pkg: constants for the laser capability register bank: register
 * indices and byte addresses, response status and error-condition codes,
 * field positions and reset values, and the bus phase type.
 * Assumes a 32-bit APB slave where register index n sits at byte 4*n.
 */
package lcr_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int unsigned LCR_ADDR_W = 12;
	localparam int unsigned LCR_DATA_W = 32;
	localparam int unsigned LCR_VAL_W  = 16;

	// ****************************************************************
	// register indices, byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] LCR_IDX_MIN_POWER  = 8'h50;
	localparam logic [7:0] LCR_IDX_MAX_POWER  = 8'h51;
	localparam logic [7:0] LCR_IDX_LOW_THZ    = 8'h52;
	localparam logic [7:0] LCR_IDX_LOW_FRAC   = 8'h53;
	localparam logic [7:0] LCR_IDX_HIGH_THZ   = 8'h54;
	localparam logic [7:0] LCR_IDX_HIGH_FRAC  = 8'h55;
	localparam logic [7:0] LCR_IDX_MIN_GRID   = 8'h56;
	localparam logic [7:0] LCR_IDX_CTRL       = 8'h60;
	localparam logic [7:0] LCR_IDX_RESP       = 8'h61;
	localparam logic [7:0] LCR_IDX_IRQ_STATUS = 8'h62;
	localparam logic [7:0] LCR_IDX_IRQ_MASK   = 8'h63;

	localparam logic [11:0] LCR_ADDR_MIN_POWER = {2'h0, LCR_IDX_MIN_POWER, 2'h0};
	localparam logic [11:0] LCR_ADDR_MAX_POWER = {2'h0, LCR_IDX_MAX_POWER, 2'h0};
	localparam logic [11:0] LCR_ADDR_LOW_THZ   = {2'h0, LCR_IDX_LOW_THZ, 2'h0};
	localparam logic [11:0] LCR_ADDR_LOW_FRAC  = {2'h0, LCR_IDX_LOW_FRAC, 2'h0};
	localparam logic [11:0] LCR_ADDR_HIGH_THZ  = {2'h0, LCR_IDX_HIGH_THZ, 2'h0};
	localparam logic [11:0] LCR_ADDR_HIGH_FRAC = {2'h0, LCR_IDX_HIGH_FRAC, 2'h0};
	localparam logic [11:0] LCR_ADDR_MIN_GRID  = {2'h0, LCR_IDX_MIN_GRID, 2'h0};

	// ****************************************************************
	// response status and error-condition codes
	// ****************************************************************
	localparam logic [1:0] LCR_STAT_OK                     = 2'h0;
	localparam logic [1:0] LCR_STAT_EXECUTION_ERROR_STATUS = 2'h1;
	localparam logic [2:0] LCR_CODE_OK                     = 3'h0;
	localparam logic [2:0] LCR_CODE_COMMAND_IN_PROGRESS    = 3'h1;
	localparam logic [2:0] LCR_CODE_COMMAND_IGNORED        = 3'h2;
	localparam logic [2:0] LCR_CODE_EXECUTION_FAILURE      = 3'h3;
	localparam logic [2:0] LCR_CODE_VENDOR_SPECIFIC_ERROR  = 3'h4;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int unsigned LCR_RESP_STAT_LSB  = 0;
	localparam int unsigned LCR_RESP_CODE_LSB  = 4;
	localparam int unsigned LCR_EV_READ_OK     = 0;
	localparam int unsigned LCR_EV_READ_ERR    = 1;
	localparam int unsigned LCR_EV_N           = 2;
	localparam logic [2:0]  LCR_CTRL_RST       = 3'h0;
	localparam logic [1:0]  LCR_IRQ_MASK_RST   = 2'h0;
	localparam logic [1:0]  LCR_IRQ_STATUS_RST = 2'h0;

	// ****************************************************************
	// bus phase
	// ****************************************************************
	typedef enum logic [0:0] {
		LCR_PH_IDLE   = 1'b0,
		LCR_PH_ACCESS = 1'b1
	} lcr_phase_type;

endpackage : lcr_pkg

// ===== src/lcr_sync2.sv
/*
 * lcr_sync2: two flip-flop synchroniser for one level input.
 * Assumes the input may change at any time relative to sys_clk.
 */
module lcr_sync2
	import lcr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic d_async,
	output logic      q
);

	typedef struct packed {
		logic meta;
		logic sync;
	} lcr_sync_type;

	lcr_sync_type st_r;
	lcr_sync_type st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = d_async;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.sync;

endmodule : lcr_sync2

// ===== src/lcr_irq.sv
/*
 * lcr_irq: sticky event status with write-one-to-clear, a mask of the
 * same layout and one level interrupt output.
 * Assumes event and clear pulses come from logic on sys_clk.
 */
module lcr_irq
	import lcr_pkg::*;
#(
	parameter int unsigned N = LCR_EV_N
)
(
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [N-1:0] ev_set,
	input  wire logic [N-1:0] ev_clr,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] mask_wdata,
	output logic [N-1:0]      status,
	output logic [N-1:0]      mask,
	output logic              irq
);

	typedef struct packed {
		logic [N-1:0] status;
		logic [N-1:0] mask;
	} lcr_irq_state_type;

	lcr_irq_state_type st_r;
	lcr_irq_state_type st_nxt;
	logic [N-1:0]      status_nxt;

	// set wins over a clear in the same cycle
	for (genvar i = 0; i < N; i++) begin : g_bit
		assign status_nxt[i] = ev_set[i] | (st_r.status[i] & ~ev_clr[i]);
	end

	always_comb begin
		st_nxt        = st_r;
		st_nxt.status = status_nxt;
		if (mask_we) begin
			st_nxt.mask = mask_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign status = st_r.status;
	assign mask   = st_r.mask;
	assign irq    = |(st_r.status & st_r.mask);

endmodule : lcr_irq

// ===== verif/lcr_host_model.sv
/*
 * lcr_host_model: host controller that issues register accesses to the
 * capability bank over APB, one transfer per task call.
 * Assumes a sys_clk shared with the slave, and a caller that waits on the
 * clock between calls.
 */
module lcr_host_model
	import lcr_pkg::*;
(
	input  wire logic        sys_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// byte strobes used by the next transfer
	logic [3:0] strb = 4'hf;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'h0;
	end

	// ****************************************************************
	// one setup cycle, then access until pready is seen at an edge
	// ****************************************************************
	task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= we;
		paddr  <= a;
		pwdata <= wd;
		pstrb  <= strb;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		pwdata  <= ~wd;
	endtask : xfer

	// host side pairing of a frequency word pair into GHz
	function automatic int ghz(input logic [15:0] thz, input logic [15:0] frac);
		return int'(thz) * 1000 + int'(frac) / 10;
	endfunction : ghz

endmodule : lcr_host_model

// ===== verif/test_laser_capability_regs.sv
/*
 * test_laser_capability_regs: self-checking bench for lcr_top driven by
 * the host model; capability values are set through parameters.
 * Assumes lcr_pkg is compiled first.
 */
module test_laser_capability_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import lcr_pkg::*;

	localparam logic [15:0] P_MINP = 16'hfe0c;
	localparam logic [15:0] P_MAXP = 16'h0578;
	localparam logic [15:0] P_LTHZ = 16'h00c2;
	localparam logic [15:0] P_LFRC = 16'h06d6;
	localparam logic [15:0] P_HTHZ = 16'h00c4;
	localparam logic [15:0] P_HFRC = 16'h0bb8;
	localparam logic [15:0] P_GRID = 16'h0001;
	localparam logic [11:0] A_CTRL = {2'h0, LCR_IDX_CTRL, 2'h0};
	localparam logic [11:0] A_RESP = {2'h0, LCR_IDX_RESP, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, LCR_IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, LCR_IDX_IRQ_MASK, 2'h0};
	localparam logic [1:0]  S_XE   = LCR_STAT_EXECUTION_ERROR_STATUS;

	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cap_ready_pin = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	int          miscompares = 0;
	int          cmp_count = 0;
	logic [31:0] got [7];

	always #12.5 sys_clk = ~sys_clk;

	lcr_top #(.MIN_POWER(P_MINP), .MAX_POWER(P_MAXP), .LOW_THZ(P_LTHZ), .LOW_FRAC(P_LFRC),
		.HIGH_THZ(P_HTHZ), .HIGH_FRAC(P_HFRC), .MIN_GRID(P_GRID)) lcr_top_inst (
		.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap_ready_pin(cap_ready_pin), .irq(irq));

	lcr_host_model lcr_host_model_inst (
		.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ****************************************************************
	// compare and access helpers
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] exp, input logic eexp, input string nm);
		logic [31:0] r;
		logic        e;
		lcr_host_model_inst.xfer(we, a, d, r, e);
		if (!we)
			chk(nm, r, exp);
		chk({nm, " err"}, {31'h0, e}, {31'h0, eexp});
	endtask : acc

	task automatic rd_cap(input int i, input logic [11:0] a, input logic [15:0] v);
		logic e;
		lcr_host_model_inst.xfer(1'b0, a, 32'h0, got[i], e);
		chk("cap", got[i], {16'h0, v});
		chk("cap err", {31'h0, e}, 32'h0);
	endtask : rd_cap

	task automatic irq_is(input logic v);
		@(posedge sys_clk);
		chk("irq", {31'h0, irq}, {31'h0, v});
	endtask : irq_is

	function automatic logic [31:0] resp(input logic [1:0] st, input logic [2:0] cd);
		return {25'h0, cd, 2'h0, st};
	endfunction : resp

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// watchdog
	// ****************************************************************
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		tally_and_finish;
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		// capability data not yet available: read fails in progress
		acc(0, LCR_ADDR_MIN_POWER, 0, 32'h0, 0, "early");
		acc(0, A_RESP, 0, resp(S_XE, LCR_CODE_COMMAND_IN_PROGRESS), 0, "resp");
		acc(0, A_STAT, 0, 32'h2, 0, "status");
		irq_is(1'b0);
		acc(1, A_MASK, 32'h2, 0, 0, "mask");
		acc(0, A_MASK, 0, 32'h2, 0, "mask rd");
		irq_is(1'b1);
		acc(1, A_STAT, 32'h2, 0, 0, "w1c");
		irq_is(1'b0);
		cap_ready_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_cap(0, LCR_ADDR_MIN_POWER, P_MINP);
		rd_cap(1, LCR_ADDR_MAX_POWER, P_MAXP);
		rd_cap(2, LCR_ADDR_LOW_THZ, P_LTHZ);
		rd_cap(3, LCR_ADDR_LOW_FRAC, P_LFRC);
		rd_cap(4, LCR_ADDR_HIGH_THZ, P_HTHZ);
		rd_cap(5, LCR_ADDR_HIGH_FRAC, P_HFRC);
		rd_cap(6, LCR_ADDR_MIN_GRID, P_GRID);
		acc(0, A_RESP, 0, resp(LCR_STAT_OK, LCR_CODE_OK), 0, "resp ok");
		acc(0, A_CTRL, 0, 32'h0, 0, "ctrl kept");
		chk("low ghz", lcr_host_model_inst.ghz(got[2][15:0], got[3][15:0]), 32'h0002_f67f);
		chk("high ghz", lcr_host_model_inst.ghz(got[4][15:0], got[5][15:0]), 32'h0002_fecc);
		chk("grid positive", {31'h0, got[6][15:0] != 16'h0}, 32'h1);
		// every error code in turn, then a value that forces nothing
		for (int k = 1; k <= 4; k++) begin
			acc(1, A_CTRL, 32'(k), 0, 0, "ctrl");
			acc(0, LCR_ADDR_MIN_GRID, 0, 32'h0, 0, "forced");
			acc(0, A_RESP, 0, resp(LCR_STAT_EXECUTION_ERROR_STATUS, 3'(k)), 0, "code");
		end
		irq_is(1'b1);
		acc(1, A_CTRL, 32'h5, 0, 0, "ctrl");
		rd_cap(6, LCR_ADDR_MIN_GRID, P_GRID);
		// a control write without its low strobe has no effect
		lcr_host_model_inst.strb = 4'h0;
		acc(1, A_CTRL, 32'h3, 0, 0, "ctrl nostrb");
		lcr_host_model_inst.strb = 4'hf;
		acc(0, A_CTRL, 0, 32'h5, 0, "ctrl strb");
		acc(1, A_STAT, 32'h3, 0, 0, "w1c");
		irq_is(1'b0);
		// refused accesses leave the bank untouched
		acc(1, A_MASK, 32'h3, 0, 0, "mask");
		acc(1, LCR_ADDR_MIN_POWER, 32'h1234, 0, 1, "ro write");
		rd_cap(0, LCR_ADDR_MIN_POWER, P_MINP);
		irq_is(1'b1);
		// reset in mid-run clears outputs, control and events
		nrst <= 1'b0;
		irq_is(1'b0);
		chk("rst rdata", prdata, 32'h0);
		chk("rst ready", {31'h0, pready}, 32'h0);
		nrst <= 1'b1;
		acc(0, A_CTRL, 0, 32'h0, 0, "rst ctrl");
		acc(0, A_STAT, 0, 32'h0, 0, "rst status");
		acc(0, 12'h000, 0, 32'h0, 1, "unmapped");
		acc(0, 12'h141, 0, 32'h0, 1, "misaligned");
		tally_and_finish;
	end

endmodule : test_laser_capability_regs
